// ---- hdl/dtpc_timer_pair.sv ----
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module dtpc_timer_pair
  import dtpc_pkg::*;
(
  input  wire logic              clock,     // peripheral clock, 10 MHz
  input  wire logic              rstn,      // async reset, active low
  input  wire logic              clkEn,     // freezes all state while low
  input  wire logic              idleMode,  // device is in Idle, same clock domain
  input  wire logic              extPinLo,  // lower external count/gate pin
  input  wire logic              extPinHi,  // upper external count/gate pin
  input  wire logic [ADDR_W-1:0] addr,      // register address
  input  wire logic [DATA_W-1:0] wrData,    // register write data
  input  wire logic              wrStb,     // write strobe
  input  wire logic              rdStb,     // read strobe
  output logic      [DATA_W-1:0] rdData,    // read data, cycle after strobe
  output logic                   flagLo,    // lower interrupt flag
  output logic                   flagHi     // upper interrupt flag
);
  // registers
  logic [15:0] ctlLo_q;
  logic [15:0] ctlHi_q;
  logic [15:0] perLo_q;
  logic [15:0] perHi_q;
  logic [15:0] cntLo_q;
  logic [15:0] cntHi_q;
  logic        flagLo_q;
  logic        flagHi_q;
  logic [15:0] rdData_q;

  // pin synchronisers and edge history
  logic        pinLoS1_q;
  logic        pinLoS2_q;
  logic        pinLoS3_q;
  logic        pinHiS1_q;
  logic        pinHiS2_q;
  logic        pinHiS3_q;

  // decoded controls
  logic        pair;
  logic        runLo;
  logic        runHi;
  logic        gatedLo;
  logic        gatedHi;
  logic        tickLo;
  logic        tickHi;
  logic        stepLo;
  logic        stepHi;
  logic        riseLo;
  logic        riseHi;
  logic        fallLo;
  logic        fallHi;
  logic        gateFallLo;
  logic        gateFallHi;
  logic        matchLo;
  logic        matchHi;
  logic        match32;
  logic        setLo;
  logic        setHi;
  logic        clrLo;
  logic        clrHi;
  logic        wrCntLo;
  logic        wrCntHi;

  assign pair = ctlLo_q[PAIR_BIT];

  // lower controls always drive the low word; they also govern the pair
  assign runLo = ctlLo_q[RUN_BIT] && !(idleMode && ctlLo_q[IDLE_BIT]);
  // the upper control is dead while paired
  assign runHi = !pair && ctlHi_q[RUN_BIT] && !(idleMode && ctlHi_q[IDLE_BIT]);

  assign gatedLo = ctlLo_q[GATE_BIT] && !ctlLo_q[CS_BIT];
  assign gatedHi = ctlHi_q[GATE_BIT] && !ctlHi_q[CS_BIT];

  // two flops on each pin before any edge or level logic looks at it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinLoS1_q <= 1'b0;
      pinLoS2_q <= 1'b0;
      pinLoS3_q <= 1'b0;
      pinHiS1_q <= 1'b0;
      pinHiS2_q <= 1'b0;
      pinHiS3_q <= 1'b0;
    end else if (clkEn) begin
      pinLoS1_q <= extPinLo;
      pinLoS2_q <= pinLoS1_q;
      pinLoS3_q <= pinLoS2_q;
      pinHiS1_q <= extPinHi;
      pinHiS2_q <= pinHiS1_q;
      pinHiS3_q <= pinHiS2_q;
    end
  end

  assign riseLo = pinLoS2_q && !pinLoS3_q;
  assign riseHi = pinHiS2_q && !pinHiS3_q;
  assign fallLo = !pinLoS2_q && pinLoS3_q;
  assign fallHi = !pinHiS2_q && pinHiS3_q;

  // external source counts pin rising edges; gated internal counts while pin high
  assign tickLo = ctlLo_q[CS_BIT] ? riseLo : (gatedLo ? pinLoS2_q : 1'b1);
  assign tickHi = ctlHi_q[CS_BIT] ? riseHi : (gatedHi ? pinHiS2_q : 1'b1);

  assign gateFallLo = clkEn && runLo && gatedLo && fallLo;
  assign gateFallHi = clkEn && runHi && gatedHi && fallHi;

  dtpc_prescaler u_presc_lo (
    .clock  (clock),
    .rstn   (rstn),
    .clkEn  (clkEn),
    .run    (runLo),
    .tick   (tickLo),
    .psCode (ctlLo_q[PS_MSB:PS_LSB]),
    .step   (stepLo)
  );

  dtpc_prescaler u_presc_hi (
    .clock  (clock),
    .rstn   (rstn),
    .clkEn  (clkEn),
    .run    (runHi),
    .tick   (tickHi),
    .psCode (ctlHi_q[PS_MSB:PS_LSB]),
    .step   (stepHi)
  );

  assign matchLo = (cntLo_q == perLo_q);
  assign matchHi = (cntHi_q == perHi_q);
  assign match32 = ({cntHi_q, cntLo_q} == {perHi_q, perLo_q});

  assign wrCntLo = clkEn && wrStb && (addr == OFF_CNT_LO);
  assign wrCntHi = clkEn && wrStb && (addr == OFF_CNT_HI);

  // control and period registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctlLo_q <= CTL_RESET;
      ctlHi_q <= CTL_RESET;
      perLo_q <= PER_RESET;
      perHi_q <= PER_RESET;
    end else if (clkEn && wrStb) begin
      unique case (addr)
        OFF_CTL_LO: ctlLo_q <= wrData & CTL_LO_MASK;
        OFF_CTL_HI: ctlHi_q <= wrData & CTL_HI_MASK;
        OFF_PER_LO: perLo_q <= wrData;
        OFF_PER_HI: perHi_q <= wrData;
        default:    ;
      endcase
    end
  end

  // low word counter; software write beats a step in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cntLo_q <= CNT_RESET;
    end else if (wrCntLo) begin
      cntLo_q <= wrData;
    end else if (stepLo) begin
      if (pair ? match32 : matchLo) begin
        cntLo_q <= CNT_RESET;
      end else begin
        cntLo_q <= cntLo_q + 16'h0001;
      end
    end
  end

  // high word counter: carry from the low word when paired, own step otherwise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cntHi_q <= CNT_RESET;
    end else if (wrCntHi) begin
      cntHi_q <= wrData;
    end else if (pair) begin
      if (stepLo) begin
        if (match32) begin
          cntHi_q <= CNT_RESET;
        end else if (cntLo_q == WORD_MAX) begin
          cntHi_q <= cntHi_q + 16'h0001;
        end
      end
    end else if (stepHi) begin
      cntHi_q <= matchHi ? CNT_RESET : cntHi_q + 16'h0001;
    end
  end

  // flag sources; a paired match lands only on the upper flag
  assign setLo = !pair && ((stepLo && matchLo) || gateFallLo);
  assign setHi = pair ? ((stepLo && match32) || gateFallLo)
                      : ((stepHi && matchHi) || gateFallHi);

  assign clrLo = wrStb && (addr == OFF_STATUS) && wrData[FLAG_LO_BIT];
  assign clrHi = wrStb && (addr == OFF_STATUS) && wrData[FLAG_HI_BIT];

  // write one to clear; a set in the same cycle wins so no event is lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flagLo_q <= 1'b0;
      flagHi_q <= 1'b0;
    end else if (clkEn) begin
      flagLo_q <= setLo || (flagLo_q && !clrLo);
      flagHi_q <= setHi || (flagHi_q && !clrHi);
    end
  end

  // read path; unmapped offsets return zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 16'h0000;
    end else if (clkEn) begin
      if (rdStb) begin
        unique case (addr)
          OFF_CTL_LO: rdData_q <= ctlLo_q & CTL_LO_MASK;
          OFF_CTL_HI: rdData_q <= ctlHi_q & CTL_HI_MASK;
          OFF_PER_LO: rdData_q <= perLo_q;
          OFF_PER_HI: rdData_q <= perHi_q;
          OFF_CNT_LO: rdData_q <= cntLo_q;
          OFF_CNT_HI: rdData_q <= cntHi_q;
          OFF_STATUS: rdData_q <= {14'h0000, flagHi_q, flagLo_q};
          default:    rdData_q <= 16'h0000;
        endcase
      end else begin
        rdData_q <= 16'h0000;
      end
    end
  end

  assign rdData = rdData_q;
  assign flagLo = flagLo_q;
  assign flagHi = flagHi_q;

  a_lo_run_stop: assert property (
    @(posedge clock) disable iff (!rstn)
    (!pair && !ctlLo_q[RUN_BIT] && !wrCntLo) |=> $stable(cntLo_q))
    else $error("lower timer moved while stopped");

  a_pair_run_stop: assert property (
    @(posedge clock) disable iff (!rstn)
    (pair && !ctlLo_q[RUN_BIT] && !wrCntLo && !wrCntHi)
      |=> ($stable(cntLo_q) && $stable(cntHi_q)))
    else $error("paired timer moved while stopped");

  a_idle_halt: assert property (
    @(posedge clock) disable iff (!rstn)
    (idleMode && ctlLo_q[IDLE_BIT] && !wrCntLo) |=> $stable(cntLo_q))
    else $error("lower timer counted in Idle with halt set");

  a_ext_no_gate: assert property (
    @(posedge clock) disable iff (!rstn)
    ctlLo_q[CS_BIT] |-> (!gatedLo && !gateFallLo))
    else $error("gate active with external clock");

  a_pair_ignores_hi: assert property (
    @(posedge clock) disable iff (!rstn)
    pair |-> (!runHi && !stepHi))
    else $error("upper control acted while paired");

  a_wrap_flag: assert property (
    @(posedge clock) disable iff (!rstn)
    (stepLo && !pair && matchLo && !wrCntLo) |=> (cntLo_q == CNT_RESET && flagLo_q))
    else $error("lower timer did not wrap and flag at period");

  a_pair_lo_flag: assert property (
    @(posedge clock) disable iff (!rstn)
    (pair && stepLo && match32) |=> (flagHi_q && !$rose(flagLo_q)))
    else $error("paired period match flagged the wrong timer");

  a_pair_carry: assert property (
    @(posedge clock) disable iff (!rstn)
    (pair && stepLo && !match32 && cntLo_q == WORD_MAX && !wrCntLo && !wrCntHi)
      |=> (cntLo_q == CNT_RESET && cntHi_q == $past(cntHi_q) + 16'h0001))
    else $error("low word carry not passed to high word");

  a_gate_fall: assert property (
    @(posedge clock) disable iff (!rstn)
    (gateFallLo && !pair) |=> flagLo_q)
    else $error("gate falling edge did not flag");

  a_read_zero: assert property (
    @(posedge clock) disable iff (!rstn)
    (clkEn && rdStb && addr == OFF_CTL_LO) |=> ((rdData & ~CTL_LO_MASK) == 16'h0000))
    else $error("unimplemented control bits read nonzero");

  a_pair_mode: assert property (
    @(posedge clock) disable iff (!rstn)
    (clkEn && wrStb && addr == OFF_CTL_LO && wrData[PAIR_BIT]) |=> pair)
    else $error("pair cascade bit did not take effect");

  a_ext_source: assert property (
    @(posedge clock) disable iff (!rstn)
    (ctlLo_q[CS_BIT] && !riseLo) |-> !stepLo)
    else $error("external source stepped without a pin edge");

  a_hi_ctl_reset: assert property (
    @(posedge clock) disable iff (!rstn)
    ((ctlHi_q & ~CTL_HI_MASK) == 16'h0000))
    else $error("upper control holds unimplemented bits");

  a_hi_run_stop: assert property (
    @(posedge clock) disable iff (!rstn)
    (!pair && !ctlHi_q[RUN_BIT] && !wrCntHi) |=> $stable(cntHi_q))
    else $error("upper timer moved while stopped");

  a_hi_wrap_flag: assert property (
    @(posedge clock) disable iff (!rstn)
    (stepHi && !pair && matchHi && !wrCntHi) |=> (cntHi_q == CNT_RESET && flagHi_q))
    else $error("upper timer did not wrap and flag at period");

  a_hi_gate_fall: assert property (
    @(posedge clock) disable iff (!rstn)
    (gateFallHi && !pair) |=> flagHi_q)
    else $error("upper gate falling edge did not flag");

  a_hi_ext_source: assert property (
    @(posedge clock) disable iff (!rstn)
    (ctlHi_q[CS_BIT] && !riseHi) |-> !stepHi)
    else $error("upper external source stepped without a pin edge");

  a_gate_low_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    (gatedLo && !pinLoS2_q) |-> !stepLo)
    else $error("gated timer stepped with gate low");

  a_pair_idle_halt: assert property (
    @(posedge clock) disable iff (!rstn)
    (pair && idleMode && ctlLo_q[IDLE_BIT] && !wrCntLo && !wrCntHi)
      |=> ($stable(cntLo_q) && $stable(cntHi_q)))
    else $error("paired timer counted in Idle with halt set");

  // enable low must freeze both counts, the lower control and the upper flag, a strobe on the bus included
  a_enable_freeze: assert property (
    @(posedge clock) disable iff (!rstn)
    !clkEn |=> ($stable(cntLo_q) && $stable(cntHi_q)
                && $stable(ctlLo_q) && $stable(flagHi_q)))
    else $error("state changed with clock enable low");

  a_read_idle_zero: assert property (
    @(posedge clock) disable iff (!rstn)
    (clkEn && !rdStb) |=> (rdData == 16'h0000))
    else $error("read data stood beyond its cycle");

  a_lo_flag_clear: assert property (
    @(posedge clock) disable iff (!rstn)
    (clkEn && clrLo && !setLo) |=> !flagLo_q)
    else $error("lower flag did not clear");

  a_write_beats_step: assert property (
    @(posedge clock) disable iff (!rstn)
    wrCntLo |=> (cntLo_q == $past(wrData)))
    else $error("count write lost to a step");

endmodule : dtpc_timer_pair

// ---- inc/dtpc_pkg.sv ----
package dtpc_pkg;
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 16;
  localparam int          PS_W          = 8;
  // register offsets
  localparam logic [2:0]  OFF_CTL_LO    = 3'h0;
  localparam logic [2:0]  OFF_CTL_HI    = 3'h1;
  localparam logic [2:0]  OFF_PER_LO    = 3'h2;
  localparam logic [2:0]  OFF_PER_HI    = 3'h3;
  localparam logic [2:0]  OFF_CNT_LO    = 3'h4;
  localparam logic [2:0]  OFF_CNT_HI    = 3'h5;
  localparam logic [2:0]  OFF_STATUS    = 3'h6;
  // control field positions
  localparam int          RUN_BIT       = 15;
  localparam int          IDLE_BIT      = 13;
  localparam int          GATE_BIT      = 6;
  localparam int          PS_MSB        = 5;
  localparam int          PS_LSB        = 4;
  localparam int          PAIR_BIT      = 3;
  localparam int          CS_BIT        = 1;
  // status field positions
  localparam int          FLAG_LO_BIT   = 0;
  localparam int          FLAG_HI_BIT   = 1;
  // implemented bit masks and reset values
  localparam logic [15:0] CTL_LO_MASK   = 16'hA07A;
  localparam logic [15:0] CTL_HI_MASK   = 16'hA072;
  localparam logic [15:0] STATUS_MASK   = 16'h0003;
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam logic [15:0] PER_RESET     = 16'hFFFF;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] WORD_MAX      = 16'hFFFF;
  // prescale codes and terminal counts (ratio minus one)
  localparam logic [1:0]  PS_CODE_1     = 2'h0;
  localparam logic [1:0]  PS_CODE_8     = 2'h1;
  localparam logic [1:0]  PS_CODE_64    = 2'h2;
  localparam logic [1:0]  PS_CODE_256   = 2'h3;
  localparam logic [7:0]  PS_TERM_1     = 8'h00;
  localparam logic [7:0]  PS_TERM_8     = 8'h07;
  localparam logic [7:0]  PS_TERM_64    = 8'h3F;
  localparam logic [7:0]  PS_TERM_256   = 8'hFF;
endpackage : dtpc_pkg

// ---- hdl/dtpc_prescaler.sv ----
`timescale 1ns/1ns
module dtpc_prescaler
  import dtpc_pkg::*;
(
  input  wire logic       clock,   // system clock
  input  wire logic       rstn,    // async reset, active low
  input  wire logic       clkEn,   // freezes state while low
  input  wire logic       run,     // timer allowed to advance
  input  wire logic       tick,    // one source tick
  input  wire logic [1:0] psCode,  // prescale select
  output logic            step     // one prescaled tick
);
  logic [PS_W-1:0] cnt_q;
  logic [PS_W-1:0] term;

  always_comb begin
    unique case (psCode)
      PS_CODE_1:   term = PS_TERM_1;
      PS_CODE_8:   term = PS_TERM_8;
      PS_CODE_64:  term = PS_TERM_64;
      PS_CODE_256: term = PS_TERM_256;
    endcase
  end

  assign step = clkEn && run && tick && (cnt_q >= term);

  // stopped timer drops its partial prescale so a restart begins a full period
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (clkEn) begin
      if (!run) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= (cnt_q >= term) ? '0 : cnt_q + 8'h01;
      end
    end
  end

  a_div_eight: assert property (
    @(posedge clock) disable iff (!rstn)
    (step && psCode == PS_CODE_8) |=> (!step || psCode != PS_CODE_8)[*7])
    else $error("divide by 8 stepped early");

endmodule : dtpc_prescaler

// ---- dv/tb_dual_timer_pair_control.sv ----
`timescale 1ns/1ns
module tb_dual_timer_pair_control
  import dtpc_pkg::*;
();
  typedef struct {
    logic [15:0] val;
    int          tol;
    bit          sts;
  } dtpc_exp_type;

  logic              clock    = 1'b0;
  logic              rstn     = 1'b0;
  logic              clkEn    = 1'b1;
  logic              idleMode = 1'b0;
  logic              extPinLo = 1'b0;
  logic              extPinHi = 1'b0;
  logic [ADDR_W-1:0] addr     = '0;
  logic [DATA_W-1:0] wrData   = '0;
  logic              wrStb    = 1'b0;
  logic              rdStb    = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic              flagLo;
  logic              flagHi;
  dtpc_exp_type      expQ[$];
  dtpc_exp_type      e;
  logic              pend     = 1'b0;
  logic [15:0]       diff;
  logic [15:0]       rnd;
  int                bad_count   = 0;
  int                comparisons = 0;
  int                cycles      = 0;

  always #50 clock = ~clock;

  dtpc_timer_pair u_dut (
    .clock    (clock),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .idleMode (idleMode),
    .extPinLo (extPinLo),
    .extPinHi (extPinHi),
    .addr     (addr),
    .wrData   (wrData),
    .wrStb    (wrStb),
    .rdStb    (rdStb),
    .rdData   (rdData),
    .flagLo   (flagLo),
    .flagHi   (flagHi)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // each task drives after an edge and returns at the edge that takes the strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    rdStb  <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [15:0] v, input int t);
    addr  <= a;
    rdStb <= 1'b1;
    wrStb <= 1'b0;
    expQ.push_back('{v, t, a == OFF_STATUS});
    @(posedge clock);
  endtask : rd

  task automatic idle(input int n);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle

  // start from zero counts and run the lower timer for n cycles under ctl
  task automatic runFor(input logic [15:0] ctl, input int n);
    wr(OFF_CNT_LO, 16'h0000);
    wr(OFF_CNT_HI, 16'h0000);
    wr(OFF_CTL_LO, ctl);
    idle(n - 1);
    wr(OFF_CTL_LO, ctl & 16'h7FFF);
  endtask : runFor

  // read data stands only in the cycle after the strobe, so look at it mid-cycle
  always @(posedge clock) begin
    pend <= rdStb;
  end

  always @(negedge clock) begin
    if (pend) begin
      e = expQ.pop_front();
      comparisons++;
      diff = (rdData > e.val) ? rdData - e.val : e.val - rdData;
      if ($isunknown(rdData) || diff > e.tol[15:0]) begin
        bad_count++;
        $display("ERROR %0t read %h expected %h", $time, rdData, e.val);
      end
      // status reads happen with timers stopped, so the flag pins must agree
      if (e.sts) begin
        comparisons++;
        if ({flagHi, flagLo} !== e.val[1:0]) begin
          bad_count++;
          $display("ERROR %0t flags %b expected %b", $time, {flagHi, flagLo}, e.val[1:0]);
        end
      end
    end
  end

  always @(posedge clock) begin
    cycles++;
    extPinHi <= $urandom;
    if (cycles == 14000) begin
      bad_count++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
    end
  end

  initial begin
    void'($urandom(27723));
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(OFF_CTL_LO, CTL_RESET, 0);
    rd(OFF_CTL_HI, CTL_RESET, 0);
    rd(OFF_PER_LO, PER_RESET, 0);
    rd(OFF_STATUS, 16'h0000, 0);
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      wr(OFF_CTL_LO, rnd & 16'h7FFF);
      rd(OFF_CTL_LO, rnd & 16'h7FFF & CTL_LO_MASK, 0);
      wr(OFF_CTL_HI, rnd & 16'h7FFF);
      rd(OFF_CTL_HI, rnd & 16'h7FFF & CTL_HI_MASK, 0);
      wr(OFF_CNT_LO, rnd);
      rd(OFF_CNT_LO, rnd, 0);
      wr(3'h7, rnd);
      rd(3'h7, 16'h0000, 0);
    end
    wr(OFF_CTL_HI, 16'h0000);
    // every prescale code, 1024 cycles each
    for (int c = 0; c < 4; c++) begin
      runFor(16'h8000 | 16'(c << 4), 1024);
      rd(OFF_CNT_LO, 16'd1024 >> (3 * c - (c == 3 ? 1 : 0)), 1);
    end
    wr(OFF_PER_LO, 16'h0005);
    runFor(16'h8000, 40);
    rd(OFF_CNT_LO, 16'h0004, 1);
    rd(OFF_STATUS, 16'h0001, 0);
    wr(OFF_STATUS, 16'h0001);
    rd(OFF_STATUS, 16'h0000, 0);
    wr(OFF_PER_LO, 16'hFFFF);
    idleMode <= 1'b1;
    runFor(16'hA000, 100);
    rd(OFF_CNT_LO, 16'h0000, 0);
    runFor(16'h8000, 100);
    rd(OFF_CNT_LO, 16'd100, 1);
    idleMode <= 1'b0;
    // external pin edges, gate bit set must be ignored
    wr(OFF_CNT_LO, 16'h0000);
    wr(OFF_CTL_LO, 16'h8042);
    for (int i = 0; i < 10; i++) begin
      extPinLo <= 1'b1;
      idle(2);
      extPinLo <= 1'b0;
      idle(2);
    end
    idle(6);
    wr(OFF_CTL_LO, 16'h0042);
    rd(OFF_CNT_LO, 16'd10, 0);
    rd(OFF_STATUS, 16'h0000, 0);
    // gated accumulation on the internal clock
    wr(OFF_CNT_LO, 16'h0000);
    wr(OFF_CTL_LO, 16'h8040);
    idle(5);
    extPinLo <= 1'b1;
    idle(30);
    extPinLo <= 1'b0;
    idle(10);
    wr(OFF_CTL_LO, 16'h0040);
    rd(OFF_CNT_LO, 16'd30, 1);
    rd(OFF_STATUS, 16'h0001, 0);
    wr(OFF_STATUS, 16'h0003);
    // paired: upper controls hold a slow prescale that must be ignored
    wr(OFF_CTL_HI, 16'h0030);
    wr(OFF_PER_HI, 16'hFFFF);
    wr(OFF_CNT_LO, 16'hFFF0);
    wr(OFF_CNT_HI, 16'h0000);
    wr(OFF_CTL_LO, 16'h8008);
    idle(31);
    wr(OFF_CTL_LO, 16'h0008);
    rd(OFF_CNT_HI, 16'h0001, 0);
    rd(OFF_CNT_LO, 16'h0010, 1);
    wr(OFF_PER_HI, 16'h0000);
    wr(OFF_PER_LO, 16'h0008);
    runFor(16'h8008, 20);
    rd(OFF_STATUS, 16'h0002, 0);
    rd(OFF_CNT_HI, 16'h0000, 0);
    wr(OFF_STATUS, 16'h0003);
    rd(OFF_STATUS, 16'h0000, 0);
    // paired timer keeps counting in Idle only with idle-halt cleared
    wr(OFF_PER_LO, 16'hFFFF);
    wr(OFF_PER_HI, 16'hFFFF);
    idleMode <= 1'b1;
    runFor(16'h8008, 50);
    rd(OFF_CNT_LO, 16'd50, 0);
    runFor(16'hA008, 50);
    rd(OFF_CNT_LO, 16'h0000, 0);
    idleMode <= 1'b0;
    // upper timer alone with its own period and flag
    wr(OFF_CTL_LO, 16'h0000);
    wr(OFF_PER_HI, 16'h0003);
    wr(OFF_CNT_HI, 16'h0000);
    wr(OFF_CTL_HI, 16'h8000);
    idle(9);
    wr(OFF_CTL_HI, 16'h0000);
    rd(OFF_CNT_HI, 16'h0002, 0);
    rd(OFF_STATUS, 16'h0002, 0);
    wr(OFF_STATUS, 16'h0003);
    // enable low freezes the count and refuses a count write
    wr(OFF_CNT_LO, 16'h0000);
    wr(OFF_CTL_LO, 16'h8000);
    idle(9);
    clkEn <= 1'b0;
    wr(OFF_CNT_LO, 16'h1234);
    idle(19);
    clkEn <= 1'b1;
    wr(OFF_CTL_LO, 16'h0000);
    rd(OFF_CNT_LO, 16'd10, 0);
    rd(OFF_STATUS, 16'h0000, 0);
    idle(4);
    conclude();
  end
endmodule : tb_dual_timer_pair_control
